// ===== swi_identity.sv
// identity layer, crc checker, add-only memory and command fifo
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// byte fifo with registered flags and head word
module swi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   // depth must be a power of two so the pointers wrap on their own
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic in_ready;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } swi_fifo_state_type;
   swi_fifo_state_type s, next_s;

   // pointer and flag update; flags are recomputed from the next count
   always_comb begin
      logic push;
      logic pop;
      push = in_valid & s.in_ready;
      pop = s.out_valid & out_ready;
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         next_s.wr = '0;
         next_s.rd = '0;
         next_s.cnt = '0;
      end
      next_s.in_ready = next_s.cnt != (AW+1)'(DEPTH);
      next_s.out_valid = next_s.cnt != '0;
      next_s.out_data = next_s.mem[next_s.rd];
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{mem: '0, wr: '0, rd: '0, cnt: '0, in_ready: 1'b1,
                out_valid: 1'b0, out_data: '0};
      end else begin
         s <= next_s;
      end
   end

   assign in_ready = s.in_ready;
   assign out_valid = s.out_valid;
   assign out_data = s.out_data;
endmodule : swi_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - 64-bit identity: family, serial, crc
// - crc polynomial x8+x5+x4+1, bitwise
// - accumulator cleared before first identity bit
// - family lsb first, then serial lsb first
// - after 56 bits accumulator equals stored crc
// - all 64 bits leave accumulator zero
// - memory commands refused until identity command done
// - read, match, search, skip select one device
// - bytes travel least significant bit first
// - programming only clears bits
// - 1024 bits as four 256-bit pages
// - protected page refuses programming, reads allowed
// - redirection bytes point to replacement page (code stores them, reads are not redirected)
// - high-voltage flag qualifies programming
// - presence answered on bus reset
module swi_identity (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // bit-slot layer
   input wire logic bus_rst,
   input wire logic rx_valid,
   input wire logic rx_bit,
   output logic rx_ready,
   output logic tx_valid,
   output logic tx_bit,
   input wire logic tx_ready,
   output logic presence,
   // programming voltage detector pin
   input wire logic prog_volt_pin,
   // status
   output logic mem_access_en,
   output logic id_crc_ok,
   output logic hv_flag,
   // memory-function command bytes
   output logic cmd_valid,
   output logic [7:0] cmd_data,
   input wire logic cmd_ready,
   // programming port
   input wire logic prog_req,
   input wire logic prog_status,
   input wire logic [6:0] prog_addr,
   input wire logic [7:0] prog_data,
   output logic prog_ack,
   output logic prog_fail,
   // read port
   input wire logic rd_req,
   input wire logic rd_status,
   input wire logic [6:0] rd_addr,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   localparam logic [63:0] ID = {
      swi_pkg::crc_body({swi_pkg::SERIAL_NUM, swi_pkg::FAMILY_CODE}),
      swi_pkg::SERIAL_NUM, swi_pkg::FAMILY_CODE};

   typedef struct packed {
      swi_pkg::swi_state_type st;
      logic [6:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] crc;
      logic sel;
      logic pend;
      logic rx_ready;
      logic tx_valid;
      logic tx_bit;
      logic presence;
      logic crc_ok;
      logic hv_s1;
      logic hv_s2;
      logic [swi_pkg::MEM_BYTES-1:0][7:0] mem;
      logic [swi_pkg::STAT_BYTES-1:0][7:0] stat;
      logic prog_ack;
      logic prog_fail;
      logic rd_valid;
      logic [7:0] rd_data;
   } swi_top_state_type;
   swi_top_state_type s, next_s;

   logic fifo_in_ready;
   logic fifo_push;

   ////////////////////////////////////////////////////////////////////////////////
   // command bytes for the memory layer pass the fifo only once selected
   assign fifo_push = s.pend & fifo_in_ready;

   swi_fifo #(
      .WIDTH(swi_pkg::FIFO_WIDTH),
      .DEPTH(swi_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .flush(bus_rst),
      .in_valid(fifo_push),
      .in_data(s.shreg),
      .in_ready(fifo_in_ready),
      .out_valid(cmd_valid),
      .out_data(cmd_data),
      .out_ready(cmd_ready)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      logic take_rx;
      logic sent;
      logic idb;
      logic last;
      logic [1:0] page;
      logic ok;
      take_rx = rx_valid & s.rx_ready;
      sent = s.tx_valid & tx_ready;
      idb = ID[s.bitcnt[5:0]];
      last = s.bitcnt == swi_pkg::BITCNT_LAST;
      page = prog_addr[6:swi_pkg::PAGE_SHIFT];
      ok = 1'b0;
      next_s = s;
      next_s.presence = 1'b0;
      next_s.prog_ack = 1'b0;
      next_s.rd_valid = 1'b0;
      // synchroniser: only the second stage is read by logic
      next_s.hv_s1 = prog_volt_pin;
      next_s.hv_s2 = s.hv_s1;
      if (fifo_push) begin
         next_s.pend = 1'b0;
      end

      unique case (s.st)
         swi_pkg::SWI_CMD: begin
            if (take_rx) begin
               next_s.shreg = {rx_bit, s.shreg[7:1]}; // lsb arrives first
               next_s.bitcnt = s.bitcnt + 7'h1;
               if (s.bitcnt[2:0] == swi_pkg::BYTE_LAST) begin
                  next_s.bitcnt = '0;
                  next_s.crc = swi_pkg::CRC_INIT;
                  // first byte after reset must be an identity command
                  unique case (next_s.shreg)
                     swi_pkg::CMD_READ_ID: next_s.st = swi_pkg::SWI_READ;
                     swi_pkg::CMD_MATCH_ID: next_s.st = swi_pkg::SWI_MATCH;
                     swi_pkg::CMD_SEARCH_ID: next_s.st = swi_pkg::SWI_SRCH_A;
                     swi_pkg::CMD_SKIP_ID: begin
                        next_s.st = swi_pkg::SWI_SEL;
                        next_s.sel = 1'b1;
                     end
                     default: next_s.st = swi_pkg::SWI_QUIET;
                  endcase
               end
            end
         end
         swi_pkg::SWI_READ: begin
            // one idle cycle between bits keeps the handshake simple
            if (!s.tx_valid) begin
               next_s.tx_valid = 1'b1;
               next_s.tx_bit = idb;
            end else if (sent) begin
               next_s.tx_valid = 1'b0;
               next_s.crc = swi_pkg::crc_step(s.crc, s.tx_bit);
               next_s.bitcnt = s.bitcnt + 7'h1;
               if (last) begin
                  next_s.st = swi_pkg::SWI_SEL;
                  next_s.sel = 1'b1;
                  next_s.crc_ok = next_s.crc == 8'h00;
               end
            end
         end
         swi_pkg::SWI_MATCH: begin
            if (take_rx) begin
               next_s.crc = swi_pkg::crc_step(s.crc, rx_bit);
               next_s.bitcnt = s.bitcnt + 7'h1;
               if (rx_bit != idb) begin
                  next_s.st = swi_pkg::SWI_QUIET; // not addressed
               end else if (last) begin
                  next_s.st = swi_pkg::SWI_SEL;
                  next_s.sel = 1'b1;
                  next_s.crc_ok = next_s.crc == 8'h00;
               end
            end
         end
         swi_pkg::SWI_SRCH_A, swi_pkg::SWI_SRCH_B: begin
            // send the bit, then its complement, then hear the master's pick
            if (!s.tx_valid) begin
               next_s.tx_valid = 1'b1;
               next_s.tx_bit = (s.st == swi_pkg::SWI_SRCH_A) ? idb : ~idb;
            end else if (sent) begin
               next_s.tx_valid = 1'b0;
               next_s.st = (s.st == swi_pkg::SWI_SRCH_A) ? swi_pkg::SWI_SRCH_B
                                                          : swi_pkg::SWI_SRCH_C;
            end
         end
         swi_pkg::SWI_SRCH_C: begin
            if (take_rx) begin
               next_s.crc = swi_pkg::crc_step(s.crc, rx_bit);
               next_s.bitcnt = s.bitcnt + 7'h1;
               next_s.st = swi_pkg::SWI_SRCH_A;
               if (rx_bit != idb) begin
                  next_s.st = swi_pkg::SWI_QUIET; // drops out of the search
               end else if (last) begin
                  next_s.st = swi_pkg::SWI_SEL;
                  next_s.sel = 1'b1;
                  next_s.crc_ok = next_s.crc == 8'h00;
               end
            end
         end
         swi_pkg::SWI_SEL: begin
            // bytes assemble lsb first; a full fifo holds rx_ready low
            if (take_rx) begin
               next_s.shreg = {rx_bit, s.shreg[7:1]};
               next_s.bitcnt = s.bitcnt + 7'h1;
               if (s.bitcnt[2:0] == swi_pkg::BYTE_LAST) begin
                  next_s.pend = 1'b1;
                  next_s.bitcnt = '0;
               end
            end
         end
         swi_pkg::SWI_QUIET: begin
            // deselected devices wait silently for the next bus reset
         end
      endcase

      // bus reset drops any selection and answers with presence
      if (bus_rst) begin
         next_s.st = swi_pkg::SWI_CMD;
         next_s.bitcnt = '0;
         next_s.sel = 1'b0;
         next_s.pend = 1'b0;
         next_s.tx_valid = 1'b0;
         next_s.crc_ok = 1'b0;
         next_s.presence = 1'b1;
      end
      next_s.rx_ready = ~next_s.pend;

      // programming: selected, high voltage present, and for memory bytes the page not protected
      if (prog_req) begin
         if (prog_status) begin
            ok = s.sel & s.hv_s2;
            if (ok) begin
               // redirection bytes are add-only like the rest
               next_s.stat[prog_addr[2:0]] = s.stat[prog_addr[2:0]] & prog_data;
            end
         end else begin
            ok = s.sel & s.hv_s2 & s.stat[swi_pkg::WP_BYTE][page];
            if (ok) begin
               next_s.mem[prog_addr] = s.mem[prog_addr] & prog_data;
            end
         end
         next_s.prog_ack = 1'b1;
         next_s.prog_fail = ~ok;
      end

      // reads ignore write protection; refused reads return erased data
      if (rd_req) begin
         next_s.rd_valid = 1'b1;
         next_s.rd_data = swi_pkg::ERASED;
         if (s.sel) begin
            next_s.rd_data = rd_status ? s.stat[rd_addr[2:0]] : s.mem[rd_addr];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register; memory resets to the erased pattern
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{st: swi_pkg::SWI_CMD, bitcnt: '0, shreg: '0, crc: swi_pkg::CRC_INIT,
                sel: 1'b0, pend: 1'b0, rx_ready: 1'b1, tx_valid: 1'b0, tx_bit: 1'b0,
                presence: 1'b0, crc_ok: 1'b0, hv_s1: 1'b0, hv_s2: 1'b0,
                mem: {swi_pkg::MEM_BYTES{swi_pkg::ERASED}},
                stat: {swi_pkg::STAT_BYTES{swi_pkg::ERASED}},
                prog_ack: 1'b0, prog_fail: 1'b0, rd_valid: 1'b0,
                rd_data: swi_pkg::ERASED};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign rx_ready = s.rx_ready;
   assign tx_valid = s.tx_valid;
   assign tx_bit = s.tx_bit;
   assign presence = s.presence;
   assign mem_access_en = s.sel;
   assign id_crc_ok = s.crc_ok;
   assign hv_flag = s.hv_s2;
   assign prog_ack = s.prog_ack;
   assign prog_fail = s.prog_fail;
   assign rd_valid = s.rd_valid;
   assign rd_data = s.rd_data;
endmodule : swi_identity
`default_nettype wire

// ===== swi_pkg.sv
// shared constants, state codes and crc helpers for the single-wire identity block
`default_nettype none
package swi_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // identity layout
   localparam int ID_BITS = 64;
   localparam int FAM_BITS = 8;
   localparam int SER_BITS = 48;
   localparam int BODY_BITS = 56;
   localparam logic [7:0] FAMILY_CODE = 8'h5a; // arbitrary value
   localparam logic [47:0] SERIAL_NUM = 48'h0123_4567_89ab; // arbitrary value
   // x^8 + x^5 + x^4 + 1, bit-reversed for a right-shifting register
   localparam logic [7:0] CRC_TAPS = 8'h8c;
   localparam logic [7:0] CRC_INIT = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // identity-layer command bytes
   localparam logic [7:0] CMD_READ_ID = 8'h33;
   localparam logic [7:0] CMD_MATCH_ID = 8'h55;
   localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;
   localparam logic [7:0] CMD_SKIP_ID = 8'hcc;

   ////////////////////////////////////////////////////////////////////////////////
   // memory geometry and reset values
   localparam int MEM_BYTES = 128;
   localparam int STAT_BYTES = 8;
   localparam int PAGE_SHIFT = 5;
   localparam logic [2:0] WP_BYTE = 3'h0;
   localparam logic [7:0] ERASED = 8'hff;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam logic [6:0] BITCNT_LAST = 7'h3f;
   localparam logic [2:0] BYTE_LAST = 3'h7;

   typedef enum logic [2:0] {
      SWI_CMD = 3'h0,
      SWI_READ = 3'h1,
      SWI_MATCH = 3'h3,
      SWI_SRCH_A = 3'h2,
      SWI_SRCH_B = 3'h6,
      SWI_SRCH_C = 3'h7,
      SWI_SEL = 3'h5,
      SWI_QUIET = 3'h4
   } swi_state_type;

   ////////////////////////////////////////////////////////////////////////////////
   // one crc step: feedback is incoming bit xor lsb, shift right, fold taps
   function automatic logic [7:0] crc_step(input logic [7:0] acc, input logic b);
      logic fb;
      fb = acc[0] ^ b;
      crc_step = {1'b0, acc[7:1]} ^ (fb ? CRC_TAPS : 8'h00);
   endfunction : crc_step

   // crc over the 56 body bits, lsb of family code first
   function automatic logic [7:0] crc_body(input logic [55:0] body);
      logic [7:0] acc;
      acc = CRC_INIT;
      for (int i = 0; i < BODY_BITS; i++) begin
         acc = crc_step(acc, body[i]);
      end
      crc_body = acc;
   endfunction : crc_body
endpackage : swi_pkg
`default_nettype wire

// ===== swi_identity_props.sv
// timing checks on the ports of the single-wire identity block
`default_nettype none
module swi_identity_props (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // bit layer
   input wire logic bus_rst,
   input wire logic tx_valid,
   input wire logic tx_bit,
   input wire logic tx_ready,
   input wire logic presence,
   // status
   input wire logic prog_volt_pin,
   input wire logic mem_access_en,
   input wire logic id_crc_ok,
   input wire logic hv_flag,
   input wire logic cmd_valid,
   // memory ports
   input wire logic prog_req,
   input wire logic prog_ack,
   input wire logic prog_fail,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////
   // a bus reset drops every grant, so a stale selection cannot leak
   a_presence_pulse: assert property (bus_rst |=> presence && !mem_access_en && !id_crc_ok)
      else $error("presence or access wrong after bus reset");
   a_presence_cause: assert property (presence |-> $past(bus_rst))
      else $error("presence without bus reset");
   a_cmd_gate: assert property (cmd_valid |-> mem_access_en)
      else $error("command byte offered while locked");
   a_crc_access: assert property (id_crc_ok |-> mem_access_en)
      else $error("crc good but access not granted");
   a_prog_locked: assert property (prog_req && !mem_access_en |=> prog_ack && prog_fail)
      else $error("programming accepted while locked");
   a_prog_nohv: assert property (prog_req && !hv_flag |=> prog_ack && prog_fail)
      else $error("programming accepted without voltage");
   a_prog_ack_cause: assert property (prog_ack |-> $past(prog_req))
      else $error("acknowledge without request");
   a_read_open: assert property (rd_req |=> rd_valid)
      else $error("read not answered");
   a_read_locked: assert property (rd_req && !mem_access_en |=> rd_data == 8'hff)
      else $error("data read while locked");
   a_tx_hold: assert property (tx_valid && !tx_ready && !bus_rst |=> tx_valid && $stable(tx_bit))
      else $error("sent bit changed before taken");
   a_hv_sync: assert property ($rose(prog_volt_pin) |-> ##2 hv_flag)
      else $error("voltage flag late");
endmodule : swi_identity_props
bind swi_identity swi_identity_props swi_identity_props_i (.clock, .sys_rst, .bus_rst,
   .tx_valid, .tx_bit, .tx_ready, .presence, .prog_volt_pin, .mem_access_en, .id_crc_ok,
   .hv_flag, .cmd_valid, .prog_req, .prog_ack, .prog_fail, .rd_req, .rd_valid, .rd_data);
`default_nettype wire

// ===== swi_master_model.sv
// bit-layer bus master model facing the single-wire identity block
`default_nettype none
module swi_master_model (
   // clock
   input wire logic clock,
   // bits towards the device
   output logic rx_valid,
   output logic rx_bit,
   input wire logic rx_ready,
   // bits from the device
   input wire logic tx_valid,
   input wire logic tx_bit,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int stall = 0; // extra cycles before taking a device bit, to act slow
   int hung = 0;
   initial begin
      rx_valid = 1'b0;
      rx_bit = 1'b1;
      tx_ready = 1'b0;
   end
   ////////////////////
   // one bit out, held until the device samples ready
   task automatic send_bit(input logic b);
      int n;
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_bit <= b;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (rx_ready !== 1'b1 && n < 500);
      if (n >= 500) hung++;
      rx_valid <= 1'b0;
      rx_bit <= ~b; // released line must not show the last value
   endtask : send_bit
   task automatic send_byte(input logic [7:0] d);
      for (int i = 0; i < 8; i++) send_bit(d[i]);
   endtask : send_byte
   // one bit in: wait for an offer, optionally stall, then take it
   task automatic recv_bit(output logic b);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (tx_valid !== 1'b1 && n < 500);
      if (n >= 500) hung++;
      repeat (stall) @(posedge clock);
      tx_ready <= 1'b1;
      @(posedge clock);
      b = tx_bit;
      tx_ready <= 1'b0;
   endtask : recv_bit
   ////////////////////
   // master-side identity check value, first n bits of v, bit 0 first
   function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
      logic [7:0] acc;
      logic fb;
      acc = 8'h00;
      for (int i = 0; i < n; i++) begin
         fb = acc[0] ^ v[i];
         acc = {1'b0, acc[7:1]} ^ ({8{fb}} & 8'h8c);
      end
      return acc;
   endfunction : crc_of
endmodule : swi_master_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the single-wire identity block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, sys_rst, bus_rst, rx_valid, rx_bit, rx_ready, tx_valid, tx_bit, tx_ready;
   logic presence, prog_volt_pin, mem_access_en, id_crc_ok, hv_flag, cmd_valid, cmd_ready;
   logic prog_req, prog_status, prog_ack, prog_fail, rd_req, rd_status, rd_valid;
   logic [6:0] prog_addr, rd_addr;
   logic [7:0] prog_data, cmd_data, rd_data;
   logic [63:0] exp_id, got_id;
   logic a, b;
   int n_fail = 0;
   int check_count = 0;
   swi_identity swi_identity_i (.clock(clock), .sys_rst(sys_rst), .bus_rst(bus_rst),
      .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_bit(tx_bit), .tx_ready(tx_ready), .presence(presence), .prog_volt_pin(prog_volt_pin),
      .mem_access_en(mem_access_en), .id_crc_ok(id_crc_ok), .hv_flag(hv_flag),
      .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .prog_req(prog_req),
      .prog_status(prog_status), .prog_addr(prog_addr), .prog_data(prog_data),
      .prog_ack(prog_ack), .prog_fail(prog_fail), .rd_req(rd_req), .rd_status(rd_status),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   swi_master_model swi_master_model_i (.clock(clock), .rx_valid(rx_valid), .rx_bit(rx_bit),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready));
   ////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // a bus reset must always bring a presence answer and drop access
   task automatic bus_reset();
      @(posedge clock) bus_rst <= 1'b1;
      @(posedge clock) bus_rst <= 1'b0;
      // look just after the edge that launches the one-cycle presence pulse
      #1 chk({presence, mem_access_en}, 2'b10);
   endtask : bus_reset
   task automatic prog(input logic s, input logic [6:0] ad, input logic [7:0] d, input logic f);
      @(posedge clock) prog_req <= 1'b1;
      prog_status <= s;
      prog_addr <= ad;
      prog_data <= d;
      @(posedge clock) prog_req <= 1'b0;
      // the acknowledge stands for one cycle only, so sample it settled
      #1 chk({prog_ack, prog_fail}, {1'b1, f});
   endtask : prog
   task automatic rd(input logic s, input logic [6:0] ad, input logic [7:0] e);
      @(posedge clock) rd_req <= 1'b1;
      rd_status <= s;
      rd_addr <= ad;
      @(posedge clock) rd_req <= 1'b0;
      #1 chk({rd_valid, rd_data}, {1'b1, e});
   endtask : rd
   ////////////////////
   // locked device: programming and reads refused before any identity command
   task automatic t_locked();
      chk({rx_ready, mem_access_en, cmd_valid}, 3'b100);
      @(posedge clock) prog_volt_pin <= 1'b1;
      repeat (3) @(posedge clock);
      chk(hv_flag, 1'b1);
      prog(1'b0, 7'h00, 8'h00, 1'b1);
      rd(1'b0, 7'h00, 8'hff);
   endtask : t_locked
   // read identity with a slow master, then recheck the crc over all 64 bits
   task automatic t_read_id();
      bus_reset();
      swi_master_model_i.stall = 2;
      swi_master_model_i.send_byte(swi_pkg::CMD_READ_ID);
      for (int i = 0; i < 64; i++) swi_master_model_i.recv_bit(got_id[i]);
      chk(got_id, exp_id);
      chk(swi_master_model_i.crc_of(got_id, 64), 8'h00);
      repeat (2) @(posedge clock);
      chk({mem_access_en, id_crc_ok}, 2'b11);
      swi_master_model_i.stall = 0;
   endtask : t_read_id
   // search: true bit, complement, then the master's choice, for all 64 bits
   task automatic t_search();
      bus_reset();
      swi_master_model_i.send_byte(swi_pkg::CMD_SEARCH_ID);
      for (int i = 0; i < 64; i++) begin
         swi_master_model_i.recv_bit(a);
         swi_master_model_i.recv_bit(b);
         chk({a, b}, {exp_id[i], ~exp_id[i]});
         swi_master_model_i.send_bit(exp_id[i]);
      end
      repeat (2) @(posedge clock);
      chk(mem_access_en, 1'b1);
   endtask : t_search
   // match with a wrong or right identity; only the right one passes a command byte
   task automatic t_match(input logic [7:0] flip);
      bus_reset();
      swi_master_model_i.send_byte(swi_pkg::CMD_MATCH_ID);
      for (int k = 0; k < 8; k++) swi_master_model_i.send_byte(exp_id[8*k+:8] ^ flip);
      swi_master_model_i.send_byte(8'ha5);
      repeat (3) @(posedge clock);
      chk({mem_access_en, cmd_valid}, {2{flip == 8'h00}});
      if (flip == 8'h00) chk(cmd_data, 8'ha5);
   endtask : t_match
   // skip, then add-only writes, page protection at the page edge, redirection
   task automatic t_prog();
      bus_reset();
      swi_master_model_i.send_byte(swi_pkg::CMD_SKIP_ID);
      prog(1'b0, 7'h05, 8'hf0, 1'b0);
      prog(1'b0, 7'h05, 8'h0f, 1'b0);
      rd(1'b0, 7'h05, 8'h00);
      prog(1'b1, 7'h00, 8'hfd, 1'b0);
      prog(1'b0, 7'h20, 8'h00, 1'b1);
      prog(1'b0, 7'h1f, 8'h00, 1'b0);
      rd(1'b0, 7'h20, 8'hff);
      prog(1'b1, 7'h01, 8'hfd, 1'b0);
      rd(1'b1, 7'h01, 8'hfd);
      @(posedge clock) prog_volt_pin <= 1'b0;
      repeat (3) @(posedge clock);
      prog(1'b0, 7'h40, 8'h00, 1'b1);
   endtask : t_prog
   // fill the command buffer past its depth with the reader stalled, then drain
   task automatic t_fifo();
      int k;
      bus_reset();
      swi_master_model_i.send_byte(swi_pkg::CMD_SKIP_ID);
      for (int j = 0; j < 17; j++) swi_master_model_i.send_byte(8'(j));
      repeat (3) @(posedge clock);
      chk({rx_ready, cmd_valid}, 2'b01);
      @(posedge clock) cmd_ready <= 1'b1;
      k = 0;
      for (int n = 0; n < 100 && k < 17; n++) begin
         @(posedge clock);
         if (cmd_valid === 1'b1) begin
            chk(cmd_data, 8'(k));
            k++;
         end
      end
      cmd_ready <= 1'b0;
      @(posedge clock) chk({k[7:0], cmd_valid}, {8'h11, 1'b0});
   endtask : t_fifo
   ////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard, well beyond the under two thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge clock);
      n_fail++;
      report_and_stop();
   end
   initial begin
      {sys_rst, bus_rst, prog_volt_pin, cmd_ready, prog_req, prog_status, rd_req} = 7'h40;
      {prog_addr, rd_addr, prog_data} = 22'h0;
      rd_status = 1'b0;
      exp_id = {8'h00, swi_pkg::SERIAL_NUM, swi_pkg::FAMILY_CODE};
      exp_id[63:56] = swi_master_model_i.crc_of(exp_id, 56);
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_locked();
      t_read_id();
      t_search();
      t_match(8'h01);
      t_match(8'h00);
      t_prog();
      t_fifo();
      chk(swi_master_model_i.hung, 0);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
